// ### hw/scu_pkg.sv
// Purpose: Shared constants and carriers for the serial communication unit
// Assumes: System clock 125 MHz, link clock from the bus side
// Notes: All timing counts derive from printed times
package scu_pkg;
    localparam int unsigned CLK_MHZ = 125;
    // Bus free time, in nanoseconds
    localparam int unsigned TBUF_STD_NS = 4700;
    localparam int unsigned TBUF_FAST_NS = 1300;
    // Least times round up to whole cycles
    localparam logic [9:0] TBUF_STD_CYC = 10'((TBUF_STD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] TBUF_FAST_CYC = 10'((TBUF_FAST_NS * CLK_MHZ + 999) / 1000);
    // Repeated start limit in standard mode, in kHz
    localparam int unsigned RSTART_SCL_MAX_KHZ = 50;
    // Reset values
    localparam logic [7:0] TRANSMIT_BUFFER_RST = 8'h00;
    localparam logic [7:0] SHIFT_RST = 8'h00;

    // Operating mode
    typedef enum logic [1:0] {
        SCU_MODE_I2C,
        SCU_MODE_UART,
        SCU_MODE_SPI
    } scu_mode_e;

    // Master sequencer states
    typedef enum logic [1:0] {
        SCU_M_IDLE,
        SCU_M_WAIT_FREE,
        SCU_M_BUF_TIME,
        SCU_M_START
    } scu_mstate_e;

    // Sticky bus event flags
    typedef struct packed {
        logic start_seen;
        logic stop_seen;
        logic no_ack;
    } scu_evt_s;

    // Link side raw events toward the system domain
    typedef struct packed {
        logic start_ev;
        logic stop_ev;
        logic nack_ev;
        logic scl_fall_ev;
        logic rx_byte_ev;
    } scu_link_s;
endpackage

// ### hw/scu_link.sv
// Purpose: Link clock domain part: SPI slave shifter and UART receive bit counter
// Assumes: Link clock runs only while the peer is active
// Notes: Words cross to here by a toggle handshake with stable data
`timescale 1ns/1ps
module scu_link (
    input wire logic link_clk,
    input wire logic link_srst,
    input wire logic [7:0] load_data,
    input wire logic load_tgl,
    input wire logic clock_phase_select,
    input wire logic msb_first_select,
    input wire logic spi_mode,
    input wire logic serial_in,
    output logic serial_out,
    output logic rx_tgl,
    output logic [7:0] rx_data
);
    // Load toggle synchroniser and edge detect
    logic s1_q, s1_d;
    logic s2_q, s2_d;
    logic s3_q, s3_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] rx_q, rx_d;
    // Receive word held steady between byte ends, read by the system side
    logic [7:0] rxh_q, rxh_d;
    logic [2:0] cnt_q, cnt_d;
    logic first_q, first_d;
    logic tg_q, tg_d;
    logic out_q, out_d;

    // Next state of the shifter
    always_comb begin
        s1_d = load_tgl;
        s2_d = s1_q;
        s3_d = s2_q;
        sh_d = sh_q;
        rx_d = rx_q;
        rxh_d = rxh_q;
        cnt_d = cnt_q;
        first_d = first_q;
        tg_d = tg_q;
        out_d = out_q;
        if (s3_q != s2_q) begin
            // Write of the transmit buffer preloads the shift register
            sh_d = load_data;
            cnt_d = 3'h0;
        end else if (spi_mode) begin
            // Shift one bit per link clock
            rx_d = msb_first_select ? {rx_q[6:0], serial_in} : {serial_in, rx_q[7:1]};
            sh_d = msb_first_select ? {sh_q[6:0], 1'b0} : {1'b0, sh_q[7:1]};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
                // Byte complete: hand the receive word over
                tg_d = ~tg_q;
                rxh_d = rx_d;
                first_d = 1'b0;
                // Phase set after the first byte repeats the same single shift, so the next byte is unchanged
                if (clock_phase_select && !first_q) begin
                    sh_d = msb_first_select ? {sh_q[6:0], 1'b0} : {1'b0, sh_q[7:1]};
                end
            end
        end
        out_d = msb_first_select ? sh_d[7] : sh_d[0];
    end

    // Registers of the link domain
    always_ff @(posedge link_clk) begin
        if (link_srst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            sh_q <= scu_pkg::SHIFT_RST;
            rx_q <= scu_pkg::SHIFT_RST;
            rxh_q <= scu_pkg::SHIFT_RST;
            cnt_q <= 3'h0;
            first_q <= 1'b1;
            tg_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            sh_q <= sh_d;
            rx_q <= rx_d;
            rxh_q <= rxh_d;
            cnt_q <= cnt_d;
            first_q <= first_d;
            tg_q <= tg_d;
            out_q <= out_d;
        end
    end

    assign serial_out = out_q;
    assign rx_tgl = tg_q;
    assign rx_data = rxh_q;
endmodule

// ### hw/scu_top.sv
// Purpose: Serial communication unit: I2C master start control, bus event flags, UART busy, SPI slave
// Assumes: Bus pins arrive asynchronous; link clock is the SPI or UART peer clock
// Notes: Control bits are plain ports; no register bus
`timescale 1ns/1ps
module scu_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic link_srst,
    input wire scu_pkg::scu_mode_e mode,
    input wire logic fast_mode,
    input wire logic multi_master_select,
    input wire logic transmitter_select,
    input wire logic soft_reset_bit,
    input wire logic synchronous_mode_select,
    input wire logic clock_phase_select,
    input wire logic msb_first_select,
    input wire logic start_request_set,
    input wire logic transmit_irq_clear,
    input wire logic flags_set_start,
    input wire logic flags_set_stop,
    input wire logic flags_set_nack,
    input wire logic tx_write,
    input wire logic [7:0] tx_wdata,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic uart_rx_in,
    input wire logic spi_in,
    output logic start_request,
    output logic bus_busy_flag,
    output logic unit_active_flag,
    output logic transmit_irq_flag,
    output scu_pkg::scu_evt_s evt_flags,
    output logic framing_error,
    output logic [7:0] transmit_buffer,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic start_gen,
    output logic spi_out
);
    // Pin synchronisers: three stages, second and third read
    logic [3:0] p1_q, p2_q, p3_q;
    // Master sequencer
    scu_pkg::scu_mstate_e st_q, st_d;
    logic [9:0] free_q, free_d;
    logic stt_q, stt_d;
    logic busy_q, busy_d;
    logic transmit_irq_flag_q, transmit_irq_flag_d;
    scu_pkg::scu_evt_s ev_q, ev_d;
    logic act_q, act_d;
    logic ferr_arm_q, ferr_arm_d;
    logic ferr_q, ferr_d;
    logic [7:0] txb_q, txb_d;
    logic ld_tgl_q, ld_tgl_d;
    logic gen_q, gen_d;
    logic [3:0] ubit_q, ubit_d;
    logic [7:0] rxb_q, rxb_d;
    logic rxv_q, rxv_d;
    // Receive toggle crossing from link domain
    logic r1_q, r2_q, r3_q;
    logic link_tgl;
    logic [7:0] link_rx;
    logic link_out;
    // Cycles the bus has been free, saturating; guards the free time check
    logic [9:0] idle_run_q, idle_run_d;

    // Decoded bus conditions from synchronised pins
    logic scl_s, sda_s, scl_p, sda_p, rx_s, rx_p;
    logic start_cond, stop_cond, scl_fall, nack_cond;
    logic [9:0] tbuf_cyc;

    always_comb begin
        scl_s = p2_q[0];
        sda_s = p2_q[1];
        rx_s = p2_q[2];
        scl_p = p3_q[0];
        sda_p = p3_q[1];
        rx_p = p3_q[2];
        start_cond = scl_s && scl_p && sda_p && !sda_s;
        stop_cond = scl_s && scl_p && !sda_p && sda_s;
        scl_fall = scl_p && !scl_s;
        // Eighth clock high (start's SCL fall counted) with SDA high seen as not-acknowledge
        nack_cond = (ubit_q == 4'h8) && scl_s && !scl_p && sda_s && busy_q;
        tbuf_cyc = fast_mode ? scu_pkg::TBUF_FAST_CYC : scu_pkg::TBUF_STD_CYC;
    end

    // Pin synchroniser registers
    always_ff @(posedge clk) begin
        if (srst) begin
            p1_q <= 4'hf;
            p2_q <= 4'hf;
            p3_q <= 4'hf;
        end else begin
            p1_q <= {spi_in, uart_rx_in, sda_in, scl_in};
            p2_q <= p1_q;
            p3_q <= p2_q;
        end
    end

    // Next values of the control and flag state
    always_comb begin
        st_d = st_q;
        free_d = free_q;
        stt_d = stt_q;
        busy_d = busy_q;
        transmit_irq_flag_d = transmit_irq_flag_q;
        ev_d = ev_q;
        act_d = act_q;
        ferr_arm_d = ferr_arm_q;
        ferr_d = ferr_q;
        txb_d = txb_q;
        ld_tgl_d = ld_tgl_q;
        gen_d = 1'b0;
        ubit_d = ubit_q;
        rxb_d = rxb_q;
        rxv_d = 1'b0;
        // Bus busy tracking
        if (start_cond) begin
            busy_d = 1'b1;
            ubit_d = 4'h0;
        end else if (stop_cond) begin
            busy_d = 1'b0;
        end else if (scl_fall && busy_q) begin
            ubit_d = (ubit_q == 4'h8) ? 4'h0 : ubit_q + 4'h1;
        end
        // Free bus run length, restarted by any busy cycle
        idle_run_d = busy_d ? 10'h000 : ((idle_run_q == 10'h3ff) ? idle_run_q : idle_run_q + 10'h001);
        // Software sets flags; bus events clear them, set wins over clear
        ev_d.start_seen = flags_set_start | (ev_q.start_seen & ~start_cond);
        ev_d.stop_seen = flags_set_stop | (ev_q.stop_seen & ~stop_cond);
        ev_d.no_ack = flags_set_nack | (ev_q.no_ack & ~nack_cond);
        if (start_request_set && mode == scu_pkg::SCU_MODE_I2C) begin
            stt_d = 1'b1;
        end
        if (transmit_irq_clear) begin
            transmit_irq_flag_d = 1'b0;
        end
        unique case (st_q)
            scu_pkg::SCU_M_IDLE: begin
                if (stt_d) begin
                    st_d = scu_pkg::SCU_M_WAIT_FREE;
                end
                if (tx_write) begin
                    txb_d = tx_wdata;
                    ld_tgl_d = ~ld_tgl_q;
                end
            end
            scu_pkg::SCU_M_WAIT_FREE: begin
                // Hold off while another transaction owns the bus
                if (!busy_d) begin
                    st_d = scu_pkg::SCU_M_BUF_TIME;
                    free_d = tbuf_cyc;
                end
                // Idle wait: clock activity moves the flag, data dropped
                if (multi_master_select && transmitter_select && scl_fall) begin
                    transmit_irq_flag_d = 1'b1;
                end
            end
            scu_pkg::SCU_M_BUF_TIME: begin
                if (busy_d) begin
                    st_d = scu_pkg::SCU_M_WAIT_FREE;
                end else if (free_q <= 10'h001) begin
                    st_d = scu_pkg::SCU_M_START;
                end else begin
                    free_d = free_q - 10'h001;
                end
            end
            scu_pkg::SCU_M_START: begin
                // Issue start; request bit clears once sent
                gen_d = 1'b1;
                stt_d = 1'b0;
                transmit_irq_flag_d = 1'b1;
                st_d = scu_pkg::SCU_M_IDLE;
            end
        endcase
        // UART receive busy tracking and framing error after soft reset
        if (mode == scu_pkg::SCU_MODE_UART) begin
            if (!act_q && rx_p && !rx_s && !soft_reset_bit) begin
                act_d = 1'b1;
            end
            if (act_q && soft_reset_bit) begin
                ferr_arm_d = 1'b1;
            end
            if (synchronous_mode_select) begin
                ferr_arm_d = 1'b0;
            end
        end
        if (soft_reset_bit) begin
            act_d = 1'b0;
            stt_d = 1'b0;
            st_d = scu_pkg::SCU_M_IDLE;
        end
        // Receive word arrives from link domain
        if (r3_q != r2_q) begin
            rxb_d = link_rx;
            rxv_d = 1'b1;
            ferr_d = ferr_arm_q;
            ferr_arm_d = 1'b0;
            act_d = 1'b0;
        end
    end

    // Registers of the control and flag state
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= scu_pkg::SCU_M_IDLE;
            free_q <= 10'h000;
            stt_q <= 1'b0;
            busy_q <= 1'b0;
            transmit_irq_flag_q <= 1'b0;
            ev_q <= '0;
            act_q <= 1'b0;
            ferr_arm_q <= 1'b0;
            ferr_q <= 1'b0;
            txb_q <= scu_pkg::TRANSMIT_BUFFER_RST;
            ld_tgl_q <= 1'b0;
            gen_q <= 1'b0;
            ubit_q <= 4'h0;
            rxb_q <= 8'h00;
            rxv_q <= 1'b0;
            r1_q <= 1'b0;
            r2_q <= 1'b0;
            r3_q <= 1'b0;
            idle_run_q <= 10'h000;
        end else begin
            st_q <= st_d;
            free_q <= free_d;
            stt_q <= stt_d;
            busy_q <= busy_d;
            transmit_irq_flag_q <= transmit_irq_flag_d;
            ev_q <= ev_d;
            act_q <= act_d;
            ferr_arm_q <= ferr_arm_d;
            ferr_q <= ferr_d;
            txb_q <= txb_d;
            ld_tgl_q <= ld_tgl_d;
            gen_q <= gen_d;
            ubit_q <= ubit_d;
            rxb_q <= rxb_d;
            rxv_q <= rxv_d;
            r1_q <= link_tgl;
            r2_q <= r1_q;
            r3_q <= r2_q;
            idle_run_q <= idle_run_d;
        end
    end

    // Link domain shifter, shared by SPI transfers and UART receive
    scu_link u_link (
        .link_clk(link_clk),
        .link_srst(link_srst),
        .load_data(txb_q),
        .load_tgl(ld_tgl_q),
        .clock_phase_select(clock_phase_select),
        .msb_first_select(msb_first_select),
        .spi_mode(mode != scu_pkg::SCU_MODE_I2C),
        .serial_in((mode == scu_pkg::SCU_MODE_UART) ? uart_rx_in : spi_in),
        .serial_out(link_out),
        .rx_tgl(link_tgl),
        .rx_data(link_rx)
    );

    assign start_request = stt_q;
    assign bus_busy_flag = busy_q;
    assign unit_active_flag = act_q;
    assign transmit_irq_flag = transmit_irq_flag_q;
    assign evt_flags = ev_q;
    assign framing_error = ferr_q;
    assign transmit_buffer = txb_q;
    assign rx_byte = rxb_q;
    assign rx_valid = rxv_q;
    assign start_gen = gen_q;
    assign spi_out = link_out;

    // No start issued while the bus is busy
    start_held_a: assert property (@(posedge clk) disable iff (srst)
        gen_q |-> !busy_q) else $error("start issued on busy bus");
    // Start preceded by at least the bus free time of idle bus
    free_time_a: assert property (@(posedge clk) disable iff (srst)
        gen_q |-> idle_run_q >= tbuf_cyc) else $error("start without free time");
    // Wait state is left only on a free bus or by soft reset
    mm_wait_a: assert property (@(posedge clk) disable iff (srst)
        (st_q == scu_pkg::SCU_M_WAIT_FREE && busy_q && !stop_cond && !soft_reset_bit)
        |=> st_q == scu_pkg::SCU_M_WAIT_FREE)
        else $error("left wait while busy");
    // Writes during wait are dropped
    tx_drop_a: assert property (@(posedge clk) disable iff (srst)
        (tx_write && st_q != scu_pkg::SCU_M_IDLE) |=> $stable(txb_q)) else $error("write not dropped");
    // Start flag clears after a start condition
    flag_clear_a: assert property (@(posedge clk) disable iff (srst)
        (start_cond && !flags_set_start) |=> !ev_q.start_seen) else $error("start flag not cleared");
    // Stop flag clears after a stop condition
    stop_clear_a: assert property (@(posedge clk) disable iff (srst)
        (stop_cond && !flags_set_stop) |=> !ev_q.stop_seen) else $error("stop flag not cleared");
    // Framing error follows soft reset during receive
    ferr_mark_a: assert property (@(posedge clk) disable iff (srst)
        (rxv_q && ferr_q) |-> $past(ferr_arm_q)) else $error("framing error without cause");
    // Buffer write starts a load toggle
    preload_a: assert property (@(posedge clk) disable iff (srst)
        (tx_write && st_q == scu_pkg::SCU_M_IDLE) |=> ld_tgl_q != $past(ld_tgl_q)) else $error("no preload");
endmodule

// ### tb/scu_peer.sv
// Purpose: Far side model: another bus master on the two-wire bus, and a link clock source
// Assumes: Two-wire lines have pull-ups, so released lines idle high
// Notes: Link clock stands still between bursts; pins are driven asynchronously
`timescale 1ns/1ps
module scu_peer (
    output logic scl,
    output logic sda,
    output logic link_clk,
    output logic uart_rx,
    output logic spi_mosi
);
    // Released lines sit at the pull-up level
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        link_clk = 1'b0;
        uart_rx = 1'b1;
        spi_mosi = 1'b1;
    end

    // Another master claims the bus: data falls while clock is high
    task automatic i2c_start();
        sda = 1'b0;
        #300 scl = 1'b0;
        #300;
    endtask

    // The other master lets go: data rises while clock is high
    task automatic i2c_stop();
        sda = 1'b0;
        #300 scl = 1'b1;
        #300 sda = 1'b1;
    endtask

    // One slow clock pulse from the other master, high half of over 10 us
    task automatic i2c_clock();
        #100 scl = 1'b1;
        #10100 scl = 1'b0;
        #100;
    endtask

    // UART start bit, long enough for the system side to see the fall
    task automatic uart_start();
        uart_rx = 1'b0;
        #48;
    endtask

    // UART data bits, least significant first, one link clock each, then stop level
    task automatic uart_bits(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            uart_rx = b[i];
            #6 link_clk = 1'b1;
            #6 link_clk = 1'b0;
        end
        uart_rx = 1'b1;
    endtask

    // Runs the link clock for n periods of 12 ns, then stops it low
    task automatic link_burst(input int n);
        repeat (n) begin
            #6 link_clk = 1'b1;
            #6 link_clk = 1'b0;
        end
    endtask
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for the serial communication unit
// Assumes: 125 MHz system clock, link clock only in bursts from the peer
// Notes: Each scenario is its own task and judges its own results
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic link_srst = 1'b1;
    scu_pkg::scu_mode_e mode = scu_pkg::SCU_MODE_I2C;
    logic fast_mode = 1'b0;
    logic mm_sel = 1'b0;
    logic tr_sel = 1'b0;
    logic soft_rst = 1'b0;
    logic sync_sel = 1'b0;
    logic cph_sel = 1'b0;
    logic msb_sel = 1'b1;
    logic start_set = 1'b0;
    logic irq_clr = 1'b0;
    logic set_start = 1'b0;
    logic set_stop = 1'b0;
    logic tx_write = 1'b0;
    logic [7:0] tx_wdata = 8'h00;
    logic scl, sda, link_clk, uart_rx, mosi;
    logic start_request, bus_busy_flag, unit_active_flag, transmit_irq_flag;
    scu_pkg::scu_evt_s evt_flags;
    logic framing_error, rx_valid, start_gen, spi_out;
    logic [7:0] transmit_buffer, rx_byte;
    int mismatches = 0;
    int n_tests = 0;

    // System clock, 8 ns period
    always #4 clk = ~clk;

    scu_peer u_peer (.scl(scl), .sda(sda), .link_clk(link_clk), .uart_rx(uart_rx), .spi_mosi(mosi));

    scu_top u_dut (.clk(clk), .srst(srst), .link_clk(link_clk), .link_srst(link_srst), .mode(mode),
        .fast_mode(fast_mode), .multi_master_select(mm_sel), .transmitter_select(tr_sel),
        .soft_reset_bit(soft_rst), .synchronous_mode_select(sync_sel), .clock_phase_select(cph_sel),
        .msb_first_select(msb_sel), .start_request_set(start_set), .transmit_irq_clear(irq_clr),
        .flags_set_start(set_start), .flags_set_stop(set_stop), .flags_set_nack(1'b0),
        .tx_write(tx_write), .tx_wdata(tx_wdata), .scl_in(scl), .sda_in(sda), .uart_rx_in(uart_rx),
        .spi_in(mosi), .start_request(start_request), .bus_busy_flag(bus_busy_flag),
        .unit_active_flag(unit_active_flag), .transmit_irq_flag(transmit_irq_flag),
        .evt_flags(evt_flags), .framing_error(framing_error), .transmit_buffer(transmit_buffer),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .start_gen(start_gen), .spi_out(spi_out));

    // Counts one comparison and reports a difference
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    // Waits up to lim cycles for a flag to reach a level
    task automatic wait_lvl(ref logic sig, input logic lvl, input int lim, input string what);
        int i;
        for (i = 0; i < lim && sig !== lvl; i++) @(posedge clk);
        chk(what, {7'h00, lvl}, {7'h00, sig});
        if (sig !== lvl) tally_and_finish();
    endtask

    // Start on a busy bus waits for release plus free time; writes meanwhile are dropped
    task automatic t_busy_start(input logic fm);
        int cnt;
        logic early;
        int unsigned tb_cyc;
        tb_cyc = fm ? scu_pkg::TBUF_FAST_CYC : scu_pkg::TBUF_STD_CYC;
        early = 1'b0;
        @(posedge clk);
        fast_mode <= fm;
        mode <= scu_pkg::SCU_MODE_I2C;
        mm_sel <= 1'b1;
        tr_sel <= 1'b1;
        u_peer.i2c_start();
        wait_lvl(bus_busy_flag, 1'b1, 20, "bus busy");
        @(posedge clk) start_set <= 1'b1;
        @(posedge clk) start_set <= 1'b0;
        @(posedge clk);
        chk("start request", 8'h01, {7'h00, start_request});
        tx_write <= 1'b1;
        tx_wdata <= 8'h5a;
        @(posedge clk) tx_write <= 1'b0;
        repeat (3) @(posedge clk);
        chk("buffer in wait", fm ? 8'h3c : scu_pkg::TRANSMIT_BUFFER_RST, transmit_buffer);
        u_peer.i2c_clock();
        repeat (4) @(posedge clk);
        chk("irq flag in wait", 8'h01, {7'h00, transmit_irq_flag});
        irq_clr <= 1'b1;
        @(posedge clk) irq_clr <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq flag cleared", 8'h00, {7'h00, transmit_irq_flag});
        repeat (200) begin
            @(posedge clk);
            if (start_gen === 1'b1) early = 1'b1;
        end
        chk("start while busy", 8'h00, {7'h00, early});
        u_peer.i2c_stop();
        for (cnt = 0; cnt < 1000 && start_gen !== 1'b1; cnt++) @(posedge clk);
        chk("free time kept", 8'h01, {7'h00, cnt >= tb_cyc && cnt <= tb_cyc + 10});
        repeat (2) @(posedge clk);
        chk("start request done", 8'h00, {7'h00, start_request});
        chk("irq flag after start", 8'h01, {7'h00, transmit_irq_flag});
        tx_write <= 1'b1;
        tx_wdata <= 8'h3c;
        @(posedge clk) tx_write <= 1'b0;
        repeat (2) @(posedge clk);
        chk("buffer after start", 8'h3c, transmit_buffer);
        u_peer.link_burst(3);
        $display("test busy start fast=%0d done", fm);
    endtask

    // Start and stop events on the bus clear their own flags
    task automatic t_evt_clear();
        @(posedge clk) set_start <= 1'b1;
        @(posedge clk) set_start <= 1'b0;
        repeat (2) @(posedge clk);
        chk("start flag set", 8'h01, {7'h00, evt_flags.start_seen});
        u_peer.i2c_start();
        repeat (10) @(posedge clk);
        chk("start flag cleared", 8'h00, {7'h00, evt_flags.start_seen});
        @(posedge clk) set_stop <= 1'b1;
        @(posedge clk) set_stop <= 1'b0;
        repeat (2) @(posedge clk);
        chk("stop flag set", 8'h01, {7'h00, evt_flags.stop_seen});
        u_peer.i2c_stop();
        repeat (10) @(posedge clk);
        chk("stop flag cleared", 8'h00, {7'h00, evt_flags.stop_seen});
        $display("test event clear done");
    endtask

    // One UART byte; optional soft reset in its start bit, with or without the sync toggle
    task automatic t_uart(input logic [7:0] b, input logic rst_mid, input logic sync_fix);
        @(posedge clk);
        mode <= scu_pkg::SCU_MODE_UART;
        msb_sel <= 1'b0;
        u_peer.uart_start();
        chk("uart active", 8'h01, {7'h00, unit_active_flag});
        if (rst_mid) begin
            @(posedge clk) soft_rst <= 1'b1;
            @(posedge clk) sync_sel <= sync_fix;
            @(posedge clk) sync_sel <= 1'b0;
            @(posedge clk) soft_rst <= 1'b0;
        end
        u_peer.uart_bits(b);
        wait_lvl(rx_valid, 1'b1, 20, "uart byte");
        chk("uart data", b, rx_byte);
        chk("framing error", {7'h00, rst_mid && !sync_fix}, {7'h00, framing_error});
        chk("uart idle", 8'h00, {7'h00, unit_active_flag});
        $display("test uart rst=%0d fix=%0d done", rst_mid, sync_fix);
    endtask

    // Buffer write preloads the shifter; first bit out is the top bit
    task automatic t_spi_preload();
        @(posedge clk);
        mode <= scu_pkg::SCU_MODE_SPI;
        cph_sel <= 1'b0;
        msb_sel <= 1'b1;
        tx_write <= 1'b1;
        tx_wdata <= 8'ha5;
        @(posedge clk) tx_write <= 1'b0;
        repeat (3) @(posedge clk);
        chk("spi buffer", 8'ha5, transmit_buffer);
        u_peer.link_burst(3);
        #1;
        chk("spi first bit", 8'h01, {7'h00, spi_out});
        u_peer.link_burst(1);
        #1;
        chk("spi second bit", 8'h00, {7'h00, spi_out});
        @(posedge clk);
        tx_write <= 1'b1;
        tx_wdata <= transmit_buffer;
        @(posedge clk) tx_write <= 1'b0;
        repeat (3) @(posedge clk);
        u_peer.link_burst(3);
        #1;
        chk("spi reload bit", 8'h01, {7'h00, spi_out});
        $display("test spi preload done");
    endtask

    // Prints counts and the verdict, then ends the run
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        u_peer.link_burst(4);
        @(posedge clk) link_srst <= 1'b0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_busy_start(1'b0);
        t_busy_start(1'b1);
        t_evt_clear();
        t_uart(8'hc5, 1'b0, 1'b0);
        t_uart(8'he6, 1'b1, 1'b0);
        t_uart(8'he5, 1'b1, 1'b1);
        t_spi_preload();
        tally_and_finish();
    end
endmodule
